// *** shared/wca_pkg.sv ***
// Purpose: Shared types and constants for the wireless coexistence arbiter.
// Assumes: One system clock; the host selects the algorithm through a command strobe.
// Notes: Line numbering follows the four coexistence pins, line 1 at bit 0.
`default_nettype none
package wca_pkg;
  localparam int unsigned WCA_LINES = 4;
  localparam logic [2:0] WCA_ALG_PKT_ARB = 3'h1;
  localparam logic [2:0] WCA_ALG_LAN_MASTER = 3'h2;
  localparam logic [2:0] WCA_ALG_RADIO_MASTER = 3'h3;
  localparam logic [2:0] WCA_ALG_TWO_WIRE = 3'h4;
  localparam logic [2:0] WCA_ALG_ALT_ACCESS = 3'h5;
  localparam logic [2:0] WCA_ALG_RESET = WCA_ALG_PKT_ARB;
  localparam logic [1:0] WCA_PRIO_RESET = 2'h0;
  // Priority variants of packet traffic arbitration.
  localparam logic [1:0] WCA_PRIO_VOICE = 2'h0;
  localparam logic [1:0] WCA_PRIO_RADIO = 2'h1;
  localparam logic [1:0] WCA_PRIO_LAN = 2'h2;
  localparam logic [1:0] WCA_PRIO_ALTERNATE = 2'h3;
  localparam int unsigned WCA_LINE_1 = 0;
  localparam int unsigned WCA_LINE_2 = 1;
  localparam int unsigned WCA_LINE_3 = 2;
  localparam int unsigned WCA_LINE_4 = 3;
  localparam int unsigned WCA_SLICE_NS = 1250;
  localparam int unsigned WCA_CLK_NS = 100;
  localparam int unsigned WCA_SLICE_CYC = WCA_SLICE_NS / WCA_CLK_NS;

  // Host command: algorithm, priority variant and master choice for two-wire.
  typedef struct packed {
    logic valid;
    logic set_prio;
    logic [2:0] alg;
    logic [1:0] prio;
    logic radio_is_master;
  } wca_cmd_s;

  // Request of the local radio baseband.
  typedef struct packed {
    logic active;
    logic critical;
  } wca_req_s;
endpackage
`default_nettype wire

// *** src/wca_sync.sv ***
// Purpose: Two-flop synchroniser for a bus of asynchronous inputs.
// Assumes: Inputs arrive from outside the clock domain.
// Notes: The first stage feeds only the second stage.
`default_nettype none
module wca_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule
`default_nettype wire

// *** src/wca_arbiter.sv ***
// Purpose: Coexistence arbiter between the local radio baseband and a collocated LAN chip.
// Assumes: Coexistence pins are asynchronous; host commands are on the system clock.
// Notes: Pins are modelled as input, output and output enable per line.
//
// How it works
// RULE1 - When coexistence is enabled all four coexistence lines belong to this block.
// RULE2 - Five algorithms are selected by host command, packet traffic arbitration after reset.
// RULE3 - Under packet arbitration the medium is shared when both request, else given whole.
// RULE4 - A priority scheme protects critical links and time slicing shares simultaneous use.
// RULE5 - Each priority variant is activated by its own host command.
// RULE6 - Packet arbitration uses line 1 grant, line 2 request, line 3 status, line 4 spare; the code drives line 4 with the critical flag.
// RULE7 - In LAN-master mode the LAN chip raises the inhibit line only while it operates.
// RULE8 - In LAN-master mode the radio is suspended while line 1 is high.
// RULE9 - In radio-master mode line 2 is driven high while the radio needs to operate.
// RULE10 - In radio-master mode the LAN chip stays silent while the inhibit is high.
// RULE11 - Two-wire mode uses line 1 inbound and line 2 outbound, host picks the master.
// RULE12 - Alternating access confines the radio to its portion of each beacon interval.
// RULE13 - Alternating access synchronises on the medium-free signal on line 1.
// RULE14 - Every coexistence input passes a two-stage synchroniser before use.
`default_nettype none
module wca_arbiter
  import wca_pkg::*;
#(
  parameter int unsigned SLICE_CYC = WCA_SLICE_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic coex_enable_i,
  input wire wca_cmd_s cmd_i,
  input wire wca_req_s radio_req_i,
  input wire logic [WCA_LINES-1:0] coex_line_i,
  output logic [WCA_LINES-1:0] coex_line_o,
  output logic [WCA_LINES-1:0] coex_line_oe_o,
  output logic radio_allowed_o,
  output logic [2:0] alg_o
);
  typedef enum logic [1:0] {
    WCA_SL_RADIO = 2'b01,
    WCA_SL_LAN = 2'b10
  } wca_slice_e;

  logic [WCA_LINES-1:0] line_s;
  logic [2:0] alg_q;
  logic [2:0] alg_d;
  logic [1:0] prio_q;
  logic [1:0] prio_d;
  logic radio_master_q;
  logic radio_master_d;
  wca_slice_e slice_q;
  wca_slice_e slice_d;
  logic [15:0] slice_cnt_q;
  logic [15:0] slice_cnt_d;
  logic [WCA_LINES-1:0] out_q;
  logic [WCA_LINES-1:0] out_d;
  logic [WCA_LINES-1:0] oe_q;
  logic [WCA_LINES-1:0] oe_d;
  logic allowed_q;
  logic allowed_d;
  logic lan_req;
  logic both_req;

  function automatic logic [WCA_LINES-1:0] line_dir(input logic [2:0] alg);
    case (alg)
      WCA_ALG_PKT_ARB: line_dir = 4'hA;
      WCA_ALG_RADIO_MASTER: line_dir = 4'h2;
      WCA_ALG_TWO_WIRE: line_dir = 4'h2;
      default: line_dir = 4'h0;
    endcase
  endfunction

  // Asynchronous pins are resynchronised before any use.
  wca_sync #(.WIDTH(WCA_LINES)) u_sync ( // RULE14
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .async_i(coex_line_i),
    .sync_o(line_s)
  );

  // Host command decode.
  always_comb begin
    alg_d = alg_q;
    prio_d = prio_q;
    radio_master_d = radio_master_q;
    if (cmd_i.valid) begin
      if (cmd_i.set_prio) begin
        prio_d = cmd_i.prio; // RULE5
      end else if (cmd_i.alg >= WCA_ALG_PKT_ARB && cmd_i.alg <= WCA_ALG_ALT_ACCESS) begin
        alg_d = cmd_i.alg; // RULE2
        radio_master_d = cmd_i.radio_is_master; // RULE11
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      alg_q <= WCA_ALG_RESET; // RULE2
      prio_q <= WCA_PRIO_RESET;
      radio_master_q <= 1'b0;
    end else begin
      alg_q <= alg_d;
      prio_q <= prio_d;
      radio_master_q <= radio_master_d;
    end
  end

  // In packet arbitration the LAN request arrives on line 3 as status.
  assign lan_req = line_s[WCA_LINE_3];
  assign both_req = radio_req_i.active && lan_req;

  // Time slicing for simultaneous use, and the alternating access phase.
  always_comb begin
    slice_d = slice_q;
    slice_cnt_d = slice_cnt_q;
    if (alg_q == WCA_ALG_ALT_ACCESS) begin
      slice_cnt_d = 16'h0000;
      slice_d = line_s[WCA_LINE_1] ? WCA_SL_RADIO : WCA_SL_LAN; // RULE13
    end else if (both_req) begin
      if (slice_cnt_q >= 16'(SLICE_CYC - 1)) begin
        slice_cnt_d = 16'h0000;
        case (slice_q) // RULE4
          WCA_SL_RADIO: slice_d = WCA_SL_LAN;
          WCA_SL_LAN: slice_d = WCA_SL_RADIO;
          default: slice_d = WCA_SL_RADIO;
        endcase
      end else begin
        slice_cnt_d = slice_cnt_q + 16'h0001;
      end
    end else begin
      slice_cnt_d = 16'h0000;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      slice_q <= WCA_SL_RADIO;
      slice_cnt_q <= 16'h0000;
    end else begin
      slice_q <= slice_d;
      slice_cnt_q <= slice_cnt_d;
    end
  end

  // Pin drive and radio permission per algorithm.
  always_comb begin
    out_d = '0;
    oe_d = '0;
    allowed_d = 1'b0;
    if (coex_enable_i) begin
      oe_d = line_dir(alg_q); // RULE1
      case (alg_q)
        WCA_ALG_PKT_ARB: begin
          if (!both_req) begin
            allowed_d = radio_req_i.active; // RULE3
          end else begin
            case (prio_q) // RULE4
              WCA_PRIO_VOICE: allowed_d = radio_req_i.critical ||
                                          (slice_q == WCA_SL_RADIO);
              WCA_PRIO_RADIO: allowed_d = 1'b1;
              WCA_PRIO_LAN: allowed_d = radio_req_i.critical;
              default: allowed_d = (slice_q == WCA_SL_RADIO);
            endcase
          end
          out_d[WCA_LINE_2] = radio_req_i.active; // RULE6
          out_d[WCA_LINE_4] = radio_req_i.critical; // RULE6
        end
        WCA_ALG_LAN_MASTER: begin
          allowed_d = radio_req_i.active && !line_s[WCA_LINE_1]; // RULE8
        end
        WCA_ALG_RADIO_MASTER: begin
          out_d[WCA_LINE_2] = radio_req_i.active; // RULE9
          allowed_d = radio_req_i.active; // RULE10
        end
        WCA_ALG_TWO_WIRE: begin
          if (radio_master_q) begin
            out_d[WCA_LINE_2] = radio_req_i.active; // RULE11
            allowed_d = radio_req_i.active;
          end else begin
            allowed_d = radio_req_i.active && !line_s[WCA_LINE_1]; // RULE11
          end
        end
        WCA_ALG_ALT_ACCESS: begin
          allowed_d = radio_req_i.active && (slice_q == WCA_SL_RADIO); // RULE12
        end
        default: allowed_d = 1'b0;
      endcase
    end else begin
      allowed_d = radio_req_i.active;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      out_q <= '0;
      oe_q <= '0;
      allowed_q <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      allowed_q <= allowed_d;
    end
  end

  assign coex_line_o = out_q;
  assign coex_line_oe_o = oe_q;
  assign radio_allowed_o = allowed_q;
  assign alg_o = alg_q;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  sequence lan_busy_s;
    coex_enable_i && alg_q == WCA_ALG_LAN_MASTER && line_s[WCA_LINE_1];
  endsequence

  lan_inhibit_a: assert property (lan_busy_s |=> !radio_allowed_o) // RULE8
    else $error("radio allowed while LAN inhibit high");
  radio_inhibit_a: assert property ( // RULE9
    coex_enable_i && alg_q == WCA_ALG_RADIO_MASTER && radio_req_i.active
    |=> coex_line_o[WCA_LINE_2] && coex_line_oe_o[WCA_LINE_2])
    else $error("radio inhibit not driven");
  reset_alg_a: assert property ($fell(reset_i) |-> alg_o == WCA_ALG_PKT_ARB) // RULE2
    else $error("algorithm not default after reset");
  full_band_a: assert property ( // RULE3
    coex_enable_i && alg_q == WCA_ALG_PKT_ARB && radio_req_i.active && !lan_req
    |=> radio_allowed_o)
    else $error("full band not given");
  arb_lines_a: assert property ( // RULE6
    coex_enable_i && alg_q == WCA_ALG_PKT_ARB |=> coex_line_oe_o == 4'hA)
    else $error("wrong line directions in arbitration");
  voice_prio_a: assert property ( // RULE4
    coex_enable_i && alg_q == WCA_ALG_PKT_ARB && prio_q == WCA_PRIO_VOICE
    && radio_req_i.active && radio_req_i.critical |=> radio_allowed_o)
    else $error("critical link not protected");
  prio_cmd_a: assert property ( // RULE5
    cmd_i.valid && cmd_i.set_prio |=> prio_q == $past(cmd_i.prio))
    else $error("priority variant not taken");
  alt_slot_a: assert property ( // RULE12
    coex_enable_i && alg_q == WCA_ALG_ALT_ACCESS && slice_q != WCA_SL_RADIO
    |=> !radio_allowed_o)
    else $error("radio outside its portion");
  sync_path_a: assert property ( // RULE14
    $rose(coex_line_i[0]) ##1 coex_line_i[0] [*2] |-> line_s[0])
    else $error("synchroniser latency wrong");
endmodule
`default_nettype wire

// *** testbench/wca_lan_model.sv ***
// Purpose: Behavioural model of the collocated LAN chip on the coexistence lines.
// Assumes: The mode follows the algorithm that the arbiter reports.
// Notes: Lines that nobody drives toggle every cycle.
`default_nettype none
module wca_lan_model
  import wca_pkg::*;
(
  input wire logic mclk_i,
  input wire logic want_i,
  input wire logic [2:0] alg_i,
  input wire logic [WCA_LINES-1:0] dev_line_i,
  input wire logic [WCA_LINES-1:0] dev_oe_i,
  output logic [WCA_LINES-1:0] line_o,
  output logic lan_tx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WCA_LINES-1:0] drv;
  logic [WCA_LINES-1:0] en;
  logic flip = 1'h0;
  always @(posedge mclk_i) flip <= ~flip;
  always_comb begin
    drv = 4'h0;
    en = 4'h1;
    lan_tx_o = want_i;
    drv[WCA_LINE_1] = want_i;
    case (alg_i)
      WCA_ALG_PKT_ARB: begin
        en = 4'h5;
        drv[WCA_LINE_1] = want_i & ~dev_line_i[WCA_LINE_2];
        drv[WCA_LINE_3] = want_i;
      end
      WCA_ALG_RADIO_MASTER: begin
        en = 4'h0;
        lan_tx_o = want_i & ~dev_line_i[WCA_LINE_2];
      end
      WCA_ALG_TWO_WIRE: lan_tx_o = want_i & ~dev_line_i[WCA_LINE_2];
      default: ;
    endcase
  end
  assign line_o = (dev_oe_i & dev_line_i) | (~dev_oe_i & en & drv) | (~dev_oe_i & ~en & {4{flip}});
endmodule
`default_nettype wire

// *** testbench/wca_arbiter_test.sv ***
// Purpose: Self-checking bench of the coexistence arbiter.
// Assumes: The slice length is shortened to 3 cycles.
// Notes: Pin changes reach the outputs three edges later, four under alternating access.
`default_nettype none
module wca_arbiter_test
  import wca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'h0;
  logic reset_i = 1'h1;
  logic en = 1'h0;
  logic want = 1'h0;
  wca_cmd_s cmd = '0;
  wca_req_s req = '0;
  logic [3:0] line_w;
  logic [3:0] line_o;
  logic [3:0] oe_o;
  logic allowed;
  logic lan_tx;
  logic [2:0] alg;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  always #50 mclk_i = ~mclk_i;
  wca_arbiter #(.SLICE_CYC(3)) DUT (.mclk_i(mclk_i), .reset_i(reset_i), .coex_enable_i(en),
    .cmd_i(cmd), .radio_req_i(req), .coex_line_i(line_w), .coex_line_o(line_o),
    .coex_line_oe_o(oe_o), .radio_allowed_o(allowed), .alg_o(alg));
  wca_lan_model lan (.mclk_i(mclk_i), .want_i(want), .alg_i(alg), .dev_line_i(line_o),
    .dev_oe_i(oe_o), .line_o(line_w), .lan_tx_o(lan_tx));
  task automatic results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 600) begin
      errors++;
      results();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #10;
  endtask
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic sp, input logic [2:0] a, input logic [1:0] p, input logic rm);
    cmd = '{1'h1, sp, a, p, rm};
    step(1);
    cmd.valid = 1'h0;
    step(1);
  endtask
  task automatic t_reset;
    chk("alg", 4'h1, {1'h0, alg});
    chk("oe", 4'h0, oe_o);
    chk("allowed", 4'h0, {3'h0, allowed});
  endtask
  task automatic t_enable;
    req.active = 1'h1;
    step(1);
    chk("oe off", 4'h0, oe_o);
    chk("allowed off", 4'h1, {3'h0, allowed});
    en = 1'h1;
    step(1);
    chk("oe on", 4'hA, oe_o);
  endtask
  task automatic t_pkt_arb;
    int ones;
    ones = 0;
    step(3);
    chk("alone", 4'h1, {3'h0, allowed});
    chk("request", 4'h1, {3'h0, line_o[WCA_LINE_2]});
    want = 1'h1;
    req.critical = 1'h1;
    step(3);
    chk("critical", 4'h1, {3'h0, allowed});
    chk("spare", 4'h1, {3'h0, line_o[WCA_LINE_4]});
    req.critical = 1'h0;
    send(1'h1, 3'h1, WCA_PRIO_LAN, 1'h0);
    chk("prio lan", 4'h0, {3'h0, allowed});
    send(1'h1, 3'h1, WCA_PRIO_RADIO, 1'h0);
    chk("prio radio", 4'h1, {3'h0, allowed});
    send(1'h1, 3'h1, WCA_PRIO_ALTERNATE, 1'h0);
    repeat (8) begin
      step(1);
      ones += allowed;
    end
    chk("slices", 4'h1, {3'h0, ones > 0 && ones < 8});
    want = 1'h0;
  endtask
  task automatic t_lan_master;
    send(1'h0, 3'h2, 2'h0, 1'h0);
    chk("alg lan", 4'h2, {1'h0, alg});
    step(1);
    want = 1'h1;
    step(2);
    chk("sync", 4'h1, {3'h0, allowed});
    step(1);
    chk("inhibit", 4'h0, {3'h0, allowed});
    want = 1'h0;
    step(3);
    chk("release", 4'h1, {3'h0, allowed});
  endtask
  task automatic t_radio_master;
    send(1'h0, 3'h3, 2'h0, 1'h0);
    want = 1'h1;
    step(1);
    chk("line2", 4'h3, {2'h0, oe_o[WCA_LINE_2], line_o[WCA_LINE_2]});
    chk("lan quiet", 4'h0, {3'h0, lan_tx});
    send(1'h0, 3'h6, 2'h0, 1'h0);
    chk("bad alg", 4'h3, {1'h0, alg});
    req.active = 1'h0;
    step(1);
    chk("line2 low", 4'h0, {3'h0, line_o[WCA_LINE_2]});
  endtask
  task automatic t_two_wire;
    req.active = 1'h1;
    send(1'h0, 3'h4, 2'h0, 1'h0);
    step(2);
    chk("lan master", 4'h0, {3'h0, allowed});
    send(1'h0, 3'h4, 2'h0, 1'h1);
    chk("radio master", 4'h1, {3'h0, line_o[WCA_LINE_2]});
  endtask
  task automatic t_alt_access;
    send(1'h0, 3'h5, 2'h0, 1'h0);
    step(3);
    chk("slot", 4'h1, {3'h0, allowed});
    want = 1'h0;
    step(4);
    chk("no slot", 4'h0, {3'h0, allowed});
  endtask
  initial begin
    step(3);
    t_reset();
    reset_i = 1'h0;
    t_enable();
    t_pkt_arb();
    t_lan_master();
    t_radio_master();
    t_two_wire();
    t_alt_access();
    results();
  end
endmodule
`default_nettype wire
